// *** smpc_supply_ctl.sv ***
// Supply monitor and power-on-reset detector control with a Wishbone register slave
`timescale 1ns/1ps
// Function
// RL1 - Power-on reset loads regulator calibration with factory 1.8V value.
// RL2 - Software may overwrite the regulator calibration field.
// RL3 - Done flag clear: reload after any reset; set: reload only on power-on.
// RL4 - Regulator-supply detector on by default; disable is synchronized, state readable.
// RL5 - Software enables slow RC oscillator before disabling regulator-supply detector.
// RL6 - Regulator-supply mask blocks its reset; reads one once synchronized.
// RL7 - Software masks regulator-supply reset before toggling its detector.
// RL8 - Regulator-supply raw bit shows unmasked detector output.
// RL9 - Core-supply detector on by default; disable is synchronized, state readable.
// RL10 - Debug interface active: writing zero to core enable is ignored.
// RL11 - Core-supply mask blocks its reset; reads one once synchronized.
// RL12 - Software masks core-supply reset before toggling its detector.
// RL13 - Core-supply raw bit shows unmasked detector output.
// RL14 - Supply monitor register writable only after unlock.
// RL15 - Freeze bit makes supply monitor register read-only until reset.
// RL16 - Monitor off by default; on-indicator; enabling it disables regulator detector.
// RL17 - Sampling in DeepStop/Static, continuous otherwise, forced sampling bit overrides.
// RL18 - Sampling uses slow RC oscillator, auto-enabled; rate from rate field.
// RL19 - Control one or two: drop flag follows supply below threshold.
// RL20 - Interrupt on rising drop flag when mask set; enable write sets mask.
// RL21 - Control one gives reset on drop; control two gives flag only.
// RL22 - Every reset loads monitor calibration factory value and sets done flag.
// RL23 - Sampling request keeps slow RC oscillator running despite software clear.
// RL24 - Enables, masks and status cross through synchronizer stages.
// RL25 - Detector reset outputs gated by synchronized mask.
module smpc_supply_ctl (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic por_event,
  input wire logic debug_active,
  input wire logic sleep_deep,
  input wire logic regsupply_above,
  input wire logic coresupply_above,
  input wire logic smon_below,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  output logic regsupply_detector_on,
  output logic coresupply_detector_on,
  output logic smon_enable,
  output logic smon_sampling,
  output logic [3:0] smon_rate,
  output logic [3:0] smon_cal,
  output logic [7:0] reg_cal,
  output logic osc_slow_enable,
  output logic regsupply_por_req,
  output logic coresupply_por_req,
  output logic smon_por_req,
  output logic irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] reg_cal_r;
  logic reg_fcd_r;
  logic reg_en_r;
  logic reg_mask_r;
  logic core_en_r;
  logic core_mask_r;
  logic reg_frz_r;
  logic [1:0] sm_ctrl_r;
  logic [3:0] sm_cal_r;
  logic sm_fcd_r;
  logic sm_fs_r;
  logic [3:0] sm_rate_r;
  logic sm_frz_r;
  logic unlocked_r;
  logic imr_r;
  logic drop_r;
  logic drop_prev_r;
  logic irq_r;
  logic osc_en_r;
  logic init_done_r;
  logic [1:0] s_reg_en;
  logic [1:0] s_reg_mask;
  logic [1:0] s_core_en;
  logic [1:0] s_core_mask;
  logic [1:0] s_reg_raw;
  logic [1:0] s_core_raw;
  logic [1:0] s_smon_below;
  logic [1:0] s_debug;
  logic [1:0] s_sleep;
  logic wr;
  logic rd_ack;
  logic wr_reg;
  logic wr_sm;
  logic [31:0] rdata;
  logic reg_det_req;
  logic sm_on;
  logic [1:0] sm_ctrl_wr;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Single-cycle ack, dropped the cycle after it is given
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (&wb_sel_i);
  assign rd_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_reg = wr & (wb_adr_i[7:0] == smpc_pkg::ADDR_REGCTL) & unlocked_r & ~reg_frz_r;
  // Monitor writes need unlock and no freeze
  assign wr_sm = wr & (wb_adr_i[7:0] == smpc_pkg::ADDR_SMON) & unlocked_r & ~sm_frz_r; // RL14 RL15
  assign sm_ctrl_wr = wb_dat_i[smpc_pkg::SM_CTRL_LSB +: 2];

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= rd_ack;
  end

  // ----------------------------------------------------------------
  // Synchronizers
  // ----------------------------------------------------------------
  // Two stages each; stage zero feeds stage one, which drives the output
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg_en <= 2'h3;
      s_core_en <= 2'h3;
      s_reg_mask <= 2'h0;
      s_core_mask <= 2'h0;
      s_reg_raw <= 2'h0;
      s_core_raw <= 2'h0;
      s_smon_below <= 2'h0;
      s_debug <= 2'h0;
      s_sleep <= 2'h0;
    end
    else
    begin
      s_reg_en <= {s_reg_en[0], reg_det_req}; // RL24
      s_core_en <= {s_core_en[0], core_en_r}; // RL24
      s_reg_mask <= {s_reg_mask[0], reg_mask_r}; // RL24
      s_core_mask <= {s_core_mask[0], core_mask_r}; // RL24
      s_reg_raw <= {s_reg_raw[0], regsupply_above};
      s_core_raw <= {s_core_raw[0], coresupply_above};
      s_smon_below <= {s_smon_below[0], smon_below};
      s_debug <= {s_debug[0], debug_active};
      s_sleep <= {s_sleep[0], sleep_deep};
    end
  end

  // ----------------------------------------------------------------
  // Unlock
  // ----------------------------------------------------------------
  // Key opens one write to a protected register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      unlocked_r <= 1'b0;
    else if (wr && wb_adr_i[7:0] == smpc_pkg::ADDR_UNLOCK)
      unlocked_r <= (wb_dat_i[31:24] == smpc_pkg::UNLOCK_KEY); // RL14
    else if (wr)
      unlocked_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Calibration loading
  // ----------------------------------------------------------------
  // One cycle after release the factory load runs
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      init_done_r <= 1'b0;
    else
      init_done_r <= ~por_event; // Load waits for power-on to end
  end

  // Regulator calibration, done flag and freeze survive a system reset
  // Power-on loads factory value; later resets reload only while done flag clear
  always_ff @(posedge clk_sys)
  begin
    if (por_event)
    begin
      reg_cal_r <= smpc_pkg::REG_CAL_FACTORY; // RL1
      reg_fcd_r <= 1'b0;
      reg_frz_r <= 1'b0;
    end
    else if (!rstn)
    begin
      reg_cal_r <= reg_cal_r;
      reg_fcd_r <= reg_fcd_r;
      reg_frz_r <= reg_frz_r;
    end
    else
    begin
      if (!init_done_r && !reg_fcd_r)
      begin
        reg_cal_r <= smpc_pkg::REG_CAL_FACTORY; // RL1 RL3
        reg_fcd_r <= 1'b1; // RL3
      end
      else if (wr_reg)
        reg_cal_r <= wb_dat_i[smpc_pkg::RC_CAL_LSB +: smpc_pkg::RC_CAL_W]; // RL2
      if (wr_reg && wb_dat_i[smpc_pkg::RC_FRZ])
        reg_frz_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Detector enables and masks
  // ----------------------------------------------------------------
  // Core enable ignores a zero while debug is active
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_en_r <= 1'b1; // RL4
      core_en_r <= 1'b1; // RL9
      reg_mask_r <= 1'b0;
      core_mask_r <= 1'b0;
    end
    else if (wr_reg)
    begin
      reg_en_r <= wb_dat_i[smpc_pkg::RC_REN];
      core_en_r <= wb_dat_i[smpc_pkg::RC_CEN] | s_debug[1]; // RL10
      reg_mask_r <= wb_dat_i[smpc_pkg::RC_RMASK]; // RL6
      core_mask_r <= wb_dat_i[smpc_pkg::RC_CMASK]; // RL11
    end
    else if (s_debug[1])
    begin
      core_en_r <= 1'b1; // RL10
    end
  end

  // Monitor on turns the regulator-supply detector off
  assign reg_det_req = reg_en_r & ~sm_on; // RL16
  assign regsupply_detector_on = s_reg_en[1]; // RL4
  assign coresupply_detector_on = s_core_en[1]; // RL9
  // Reset requests gated by synchronized mask and detector state
  assign regsupply_por_req = s_reg_en[1] & ~s_reg_raw[1] & ~s_reg_mask[1]; // RL25
  assign coresupply_por_req = s_core_en[1] & ~s_core_raw[1] & ~s_core_mask[1]; // RL25

  // ----------------------------------------------------------------
  // Supply monitor register
  // ----------------------------------------------------------------
  // Calibration reloads after every reset, done flag set at once
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sm_ctrl_r <= smpc_pkg::SM_CTRL_OFF; // RL16
      sm_cal_r <= smpc_pkg::SM_CAL_FACTORY; // RL22
      sm_fcd_r <= 1'b0;
      sm_fs_r <= 1'b0;
      sm_rate_r <= 4'h0;
      sm_frz_r <= 1'b0;
    end
    else if (!init_done_r)
    begin
      sm_cal_r <= smpc_pkg::SM_CAL_FACTORY; // RL22
      sm_fcd_r <= 1'b1; // RL22
    end
    else if (wr_sm)
    begin
      sm_ctrl_r <= sm_ctrl_wr;
      sm_cal_r <= wb_dat_i[smpc_pkg::SM_CAL_LSB +: smpc_pkg::SM_CAL_W];
      sm_fs_r <= wb_dat_i[smpc_pkg::SM_FS]; // RL17
      sm_rate_r <= wb_dat_i[smpc_pkg::SM_RATE_LSB +: 4]; // RL18
      sm_frz_r <= wb_dat_i[smpc_pkg::SM_FRZ]; // RL15
    end
  end

  assign sm_on = (sm_ctrl_r == smpc_pkg::SM_CTRL_RESET) | (sm_ctrl_r == smpc_pkg::SM_CTRL_FLAG);
  assign smon_enable = sm_on; // RL16
  // Sampling in deep sleep modes or when forced
  assign smon_sampling = sm_on & (s_sleep[1] | sm_fs_r); // RL17
  assign smon_rate = sm_rate_r; // RL18
  assign smon_cal = sm_cal_r;
  assign reg_cal = reg_cal_r;

  // ----------------------------------------------------------------
  // Slow RC oscillator
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      osc_en_r <= 1'b0;
    else if (wr && wb_adr_i[7:0] == smpc_pkg::ADDR_OSC)
      osc_en_r <= wb_dat_i[smpc_pkg::OSC_EN];
  end

  // Sampling request holds oscillator on
  assign osc_slow_enable = osc_en_r | smon_sampling; // RL18 RL23

  // ----------------------------------------------------------------
  // Drop flag, interrupt and reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      drop_r <= 1'b0;
      drop_prev_r <= 1'b0;
    end
    else
    begin
      drop_r <= sm_on & s_smon_below[1]; // RL19
      drop_prev_r <= drop_r;
    end
  end

  // Mask set by enable write, cleared by disable write; set wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      imr_r <= 1'b0;
    else if (wr && wb_adr_i[7:0] == smpc_pkg::ADDR_IER && wb_dat_i[smpc_pkg::PC_DROP])
      imr_r <= 1'b1; // RL20
    else if (wr && wb_adr_i[7:0] == smpc_pkg::ADDR_IDR && wb_dat_i[smpc_pkg::PC_DROP])
      imr_r <= 1'b0;
  end

  // Rising flag with mask gives a one-cycle request
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      irq_r <= 1'b0;
    else
      irq_r <= drop_r & ~drop_prev_r & imr_r; // RL20
  end

  assign irq = irq_r;
  assign smon_por_req = drop_r & (sm_ctrl_r == smpc_pkg::SM_CTRL_RESET); // RL21

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata = 32'h0;
    case (wb_adr_i[7:0])
      smpc_pkg::ADDR_REGCTL:
      begin
        rdata[smpc_pkg::RC_CAL_LSB +: smpc_pkg::RC_CAL_W] = reg_cal_r;
        rdata[smpc_pkg::RC_FCD] = reg_fcd_r;
        rdata[smpc_pkg::RC_REN] = reg_en_r;
        rdata[smpc_pkg::RC_RST] = s_reg_en[1]; // RL4
        rdata[smpc_pkg::RC_RMASK] = s_reg_mask[1]; // RL6
        rdata[smpc_pkg::RC_RRAW] = s_reg_raw[1]; // RL8
        rdata[smpc_pkg::RC_CEN] = core_en_r;
        rdata[smpc_pkg::RC_CST] = s_core_en[1]; // RL9
        rdata[smpc_pkg::RC_CMASK] = s_core_mask[1]; // RL11
        rdata[smpc_pkg::RC_CRAW] = s_core_raw[1]; // RL13
        rdata[smpc_pkg::RC_FRZ] = reg_frz_r;
      end
      smpc_pkg::ADDR_SMON:
      begin
        rdata[smpc_pkg::SM_CTRL_LSB +: 2] = sm_ctrl_r;
        rdata[smpc_pkg::SM_CAL_LSB +: smpc_pkg::SM_CAL_W] = sm_cal_r;
        rdata[smpc_pkg::SM_FCD] = sm_fcd_r;
        rdata[smpc_pkg::SM_FS] = sm_fs_r;
        rdata[smpc_pkg::SM_ON] = sm_on; // RL16
        rdata[smpc_pkg::SM_RATE_LSB +: 4] = sm_rate_r;
        rdata[smpc_pkg::SM_FRZ] = sm_frz_r;
      end
      smpc_pkg::ADDR_PCSR: rdata[smpc_pkg::PC_DROP] = drop_r;
      smpc_pkg::ADDR_IMR: rdata[smpc_pkg::PC_DROP] = imr_r;
      smpc_pkg::ADDR_UNLOCK: rdata[0] = unlocked_r;
      smpc_pkg::ADDR_OSC: rdata[smpc_pkg::OSC_EN] = osc_slow_enable;
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      wb_dat_o <= 32'h0;
    else
      wb_dat_o <= rdata;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_FROZEN_SM: assert property (@(posedge clk_sys) disable iff (!rstn) // RL15
    sm_frz_r |=> $stable(sm_ctrl_r) && sm_frz_r)
    else $error("Frozen monitor register changed");
  AST_LOCKED_SM: assert property (@(posedge clk_sys) disable iff (!rstn) // RL14
    (init_done_r && !unlocked_r) |=> $stable(sm_ctrl_r))
    else $error("Monitor written while locked");
  AST_MASK_GATE: assert property (@(posedge clk_sys) disable iff (!rstn) // RL25
    $past(reg_mask_r, 2) |-> !regsupply_por_req)
    else $error("Masked detector asserted reset");
  AST_MASK_SYNC: assert property (@(posedge clk_sys) disable iff (!rstn) // RL24
    $rose(core_mask_r) |-> !s_core_mask[1] ##2 s_core_mask[1])
    else $error("Core mask readback timing wrong");
  AST_DEBUG_KEEP: assert property (@(posedge clk_sys) disable iff (!rstn) // RL10
    s_debug[1] |=> core_en_r)
    else $error("Core detector disabled under debug");
  AST_IRQ_EDGE: assert property (@(posedge clk_sys) disable iff (!rstn) // RL20
    (drop_r && !drop_prev_r && imr_r) |=> irq)
    else $error("Missed drop interrupt");
  AST_SM_RESET: assert property (@(posedge clk_sys) disable iff (!rstn) // RL21
    smon_por_req == (sm_ctrl_r == smpc_pkg::SM_CTRL_RESET && $past(sm_on && s_smon_below[1])))
    else $error("Monitor reset in wrong mode");
  AST_OSC_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn) // RL23
    smon_sampling |-> osc_slow_enable)
    else $error("Oscillator off while sampling");
  AST_SM_OFF_REG: assert property (@(posedge clk_sys) disable iff (!rstn) // RL16
    sm_on |-> ##2 !regsupply_detector_on)
    else $error("Regulator detector on with monitor");
  COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rstn) irq);
  COV_FREEZE: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(sm_frz_r));
  COV_SMPOR: cover property (@(posedge clk_sys) disable iff (!rstn) smon_por_req);
endmodule // smpc_supply_ctl

// *** smpc_pkg.sv ***
// Package: register map, field layout and reset values of the supply monitor and POR control
package smpc_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_REGCTL = 8'h00; // Regulator control register
  localparam logic [7:0] ADDR_SMON = 8'h04; // Supply monitor register
  localparam logic [7:0] ADDR_PCSR = 8'h08; // Power and clock status register
  localparam logic [7:0] ADDR_IER = 8'h0c; // Interrupt enable (write one to set mask)
  localparam logic [7:0] ADDR_IDR = 8'h10; // Interrupt disable (write one to clear mask)
  localparam logic [7:0] ADDR_IMR = 8'h14; // Interrupt mask register
  localparam logic [7:0] ADDR_UNLOCK = 8'h18; // Unlock register
  localparam logic [7:0] ADDR_OSC = 8'h1c; // Slow RC oscillator configuration
  // ----------------------------------------------------------------
  // Regulator control fields
  // ----------------------------------------------------------------
  localparam int RC_CAL_LSB = 0; // Calibration field, 8 bits
  localparam int RC_CAL_W = 8;
  localparam int RC_FCD = 8;
  localparam int RC_REN = 12; // Regulator-supply detector enable
  localparam int RC_RST = 13; // Regulator-supply detector state
  localparam int RC_RMASK = 14;
  localparam int RC_RRAW = 15;
  localparam int RC_CEN = 16; // Core-supply detector enable
  localparam int RC_CST = 17;
  localparam int RC_CMASK = 18;
  localparam int RC_CRAW = 19;
  localparam int RC_FRZ = 31;
  // ----------------------------------------------------------------
  // Supply monitor fields
  // ----------------------------------------------------------------
  localparam int SM_CTRL_LSB = 0; // Control field, 2 bits
  localparam int SM_CAL_LSB = 4; // Calibration, 4 bits
  localparam int SM_CAL_W = 4;
  localparam int SM_FCD = 8;
  localparam int SM_FS = 9;
  localparam int SM_ON = 10;
  localparam int SM_RATE_LSB = 12; // Sampling rate, 4 bits
  localparam int SM_FRZ = 31;
  localparam int PC_DROP = 0; // Supply drop flag position in status/masks
  localparam int OSC_EN = 0;
  // ----------------------------------------------------------------
  // Reset and factory values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CAL_FACTORY = 8'h80; // Gives nominal 1.8V output
  localparam logic [3:0] SM_CAL_FACTORY = 4'h8; // Gives nominal 1.75 V threshold
  localparam logic [7:0] UNLOCK_KEY = 8'haa;
  localparam logic [1:0] SM_CTRL_OFF = 2'h0;
  localparam logic [1:0] SM_CTRL_RESET = 2'h1;
  localparam logic [1:0] SM_CTRL_FLAG = 2'h2;
  localparam int SYNC_STAGES = 2;
endpackage

// *** smpc_supply_model.sv ***
// Behavioural model of the analog supply detectors and the reset network
`timescale 1ns/1ps
module smpc_supply_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reg_lvl,
  input wire logic core_lvl,
  input wire logic sm_low,
  input wire logic smon_enable,
  input wire logic smon_por_req,
  output logic regsupply_above,
  output logic coresupply_above,
  output logic smon_below,
  output logic [7:0] por_count
);
  logic prev_r;

  // Comparators; an unpowered monitor never reports a drop
  assign regsupply_above = reg_lvl;
  assign coresupply_above = core_lvl;
  assign smon_below = sm_low & smon_enable;

  // Reset network counts rising monitor reset requests
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_r <= 1'b0;
      por_count <= 8'h00;
    end
    else
    begin
      prev_r <= smon_por_req;
      if (smon_por_req && !prev_r)
        por_count <= por_count + 8'h01;
    end
  end
endmodule // smpc_supply_model

// *** tb_top.sv ***
// Self-checking testbench of the supply monitor and POR control block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rstn, por_event, debug_active, sleep_deep, reg_lvl, core_lvl, sm_low;
  logic regsupply_above, coresupply_above, smon_below, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q, seed, mk;
  logic [3:0] wb_sel_i, smon_rate, smon_cal, s4, r4;
  logic [7:0] reg_cal, c8, por_count;
  logic regsupply_detector_on, coresupply_detector_on, smon_enable, smon_sampling;
  logic osc_slow_enable, regsupply_por_req, coresupply_por_req, smon_por_req, irq;
  int fails, tests_run;

  smpc_supply_ctl i_smpc_supply_ctl (.clk_sys, .rstn, .por_event, .debug_active,
    .sleep_deep, .regsupply_above, .coresupply_above, .smon_below, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .regsupply_detector_on,
    .coresupply_detector_on, .smon_enable, .smon_sampling, .smon_rate, .smon_cal, .reg_cal,
    .osc_slow_enable, .regsupply_por_req, .coresupply_por_req, .smon_por_req, .irq);
  smpc_supply_model i_smpc_supply_model (.clk_sys, .rstn, .reg_lvl, .core_lvl, .sm_low,
    .smon_enable, .smon_por_req, .regsupply_above, .coresupply_above, .smon_below,
    .por_count);

  // Clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end

  task automatic give_verdict;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Regulator control word and its flag byte
  function automatic logic [31:0] rcw(input logic [7:0] c, input logic re, rm, ce, cm);
    rcw = {24'h0, c} | (32'h1 << smpc_pkg::RC_FCD);
    rcw[smpc_pkg::RC_REN] = re;
    rcw[smpc_pkg::RC_RMASK] = rm;
    rcw[smpc_pkg::RC_CEN] = ce;
    rcw[smpc_pkg::RC_CMASK] = cm;
  endfunction
  function automatic logic [31:0] flg(input logic [31:0] w);
    return {24'h0, w[smpc_pkg::RC_CRAW], w[smpc_pkg::RC_CMASK], w[smpc_pkg::RC_CST],
      w[smpc_pkg::RC_CEN], w[smpc_pkg::RC_RRAW], w[smpc_pkg::RC_RMASK],
      w[smpc_pkg::RC_RST], w[smpc_pkg::RC_REN]};
  endfunction
  // Supply monitor word
  function automatic logic [31:0] smw(input logic [1:0] c, input logic [3:0] k,
    input logic f, input logic [3:0] r, input logic on);
    smw = 32'h0;
    smw[smpc_pkg::SM_CTRL_LSB +: 2] = c;
    smw[smpc_pkg::SM_CAL_LSB +: 4] = k;
    smw[smpc_pkg::SM_FS] = f;
    smw[smpc_pkg::SM_RATE_LSB +: 4] = r;
    smw[smpc_pkg::SM_ON] = on;
  endfunction

  // Classic Wishbone single cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      give_verdict();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic uw(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, smpc_pkg::ADDR_UNLOCK, {smpc_pkg::UNLOCK_KEY, 24'h0});
    wb(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [7:0] e);
    repeat (6) @(posedge clk_sys);
    wb(1'b0, smpc_pkg::ADDR_REGCTL, 32'h0);
    chk(nm, flg(q), {24'h0, e});
  endtask
  task automatic smr(input string nm, input logic [31:0] e);
    repeat (6) @(posedge clk_sys);
    wb(1'b0, smpc_pkg::ADDR_SMON, 32'h0);
    chk(nm, q & mk, e);
  endtask

  // Main sequence
  initial
  begin
    {rstn, debug_active, sleep_deep, sm_low, wb_we_i, wb_stb_i, wb_cyc_i} = 7'h00;
    {por_event, reg_lvl, core_lvl} = 3'h7;
    {wb_adr_i, wb_dat_i} = 64'h0;
    wb_sel_i = 4'hf;
    seed = 32'd91811;
    fails = 0;
    tests_run = 0;
    mk = smw(2'h3, 4'hf, 1'b1, 4'hf, 1'b1);
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    por_event <= 1'b0;
    rc("regctl_reset", 8'hbb);
    chk("reg_cal", {24'h0, reg_cal}, {24'h0, smpc_pkg::REG_CAL_FACTORY});
    chk("reg_fcd", {31'h0, q[smpc_pkg::RC_FCD]}, 32'h1);
    reg_lvl <= 1'b0;
    core_lvl <= 1'b0;
    rc("raw_low", 8'h33);
    chk("por_reqs", {30'h0, regsupply_por_req, coresupply_por_req}, 32'h3);
    reg_lvl <= 1'b1;
    core_lvl <= 1'b1;
    // Mask, then disable, the regulator-supply detector
    uw(smpc_pkg::ADDR_REGCTL, rcw(smpc_pkg::REG_CAL_FACTORY, 1'b1, 1'b1, 1'b1, 1'b0));
    rc("reg_mask", 8'hbf);
    reg_lvl <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("reg_por_masked", {31'h0, regsupply_por_req}, 32'h0);
    reg_lvl <= 1'b1;
    wb(1'b1, smpc_pkg::ADDR_OSC, 32'h1);
    seed = xs(seed);
    c8 = seed[7:0];
    uw(smpc_pkg::ADDR_REGCTL, rcw(c8, 1'b0, 1'b1, 1'b1, 1'b0));
    rc("reg_off", 8'hbc);
    chk("reg_det_on", {31'h0, regsupply_detector_on}, 32'h0);
    chk("reg_cal_sw", {24'h0, reg_cal}, {24'h0, c8});
    uw(smpc_pkg::ADDR_REGCTL, rcw(c8, 1'b1, 1'b1, 1'b1, 1'b1));
    // Core detector stays on while debug is active
    debug_active <= 1'b1;
    uw(smpc_pkg::ADDR_REGCTL, rcw(c8, 1'b1, 1'b1, 1'b0, 1'b1));
    rc("core_debug", 8'hff);
    debug_active <= 1'b0;
    uw(smpc_pkg::ADDR_REGCTL, rcw(c8, 1'b1, 1'b1, 1'b0, 1'b1));
    rc("core_off", 8'hcf);
    chk("core_det_on", {31'h0, coresupply_detector_on}, 32'h0);
    // Locked monitor register, then unlocked write
    wb(1'b1, smpc_pkg::ADDR_SMON, smw(2'h2, 4'h3, 1'b0, 4'h5, 1'b0));
    smr("smon_locked", smw(2'h0, smpc_pkg::SM_CAL_FACTORY, 1'b0, 4'h0, 1'b0));
    chk("smon_fcd", {31'h0, q[smpc_pkg::SM_FCD]}, 32'h1);
    seed = xs(seed);
    {s4, r4} = seed[7:0];
    uw(smpc_pkg::ADDR_SMON, smw(2'h2, s4, 1'b0, r4, 1'b0));
    smr("smon_on", smw(2'h2, s4, 1'b0, r4, 1'b1));
    chk("smon_io", {24'h0, smon_rate, smon_cal}, {24'h0, r4, s4});
    chk("smon_reg_det", {30'h0, smon_enable, regsupply_detector_on}, 32'h2);
    // Sampling follows sleep depth and the force bit
    wb(1'b1, smpc_pkg::ADDR_OSC, 32'h0);
    sleep_deep <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("samp_deep", {30'h0, smon_sampling, osc_slow_enable}, 32'h3);
    sleep_deep <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("samp_run", {30'h0, smon_sampling, osc_slow_enable}, 32'h0);
    uw(smpc_pkg::ADDR_SMON, smw(2'h2, s4, 1'b1, r4, 1'b0));
    repeat (6) @(posedge clk_sys);
    chk("samp_force", {30'h0, smon_sampling, osc_slow_enable}, 32'h3);
    // Drop flag and interrupt with flag-only control
    wb(1'b1, smpc_pkg::ADDR_IER, 32'h1 << smpc_pkg::PC_DROP);
    wb(1'b0, smpc_pkg::ADDR_IMR, 32'h0);
    chk("imr", q[smpc_pkg::PC_DROP], 1'b1);
    sm_low <= 1'b1;
    for (int n = 0; n < 16 && irq !== 1'b1; n++) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'b0, smpc_pkg::ADDR_PCSR, 32'h0);
    chk("drop_set", q[smpc_pkg::PC_DROP], 1'b1);
    chk("no_por", {31'h0, smon_por_req}, 32'h0);
    sm_low <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wb(1'b0, smpc_pkg::ADDR_PCSR, 32'h0);
    chk("drop_clr", q[smpc_pkg::PC_DROP], 1'b0);
    wb(1'b1, smpc_pkg::ADDR_IDR, 32'h1 << smpc_pkg::PC_DROP);
    wb(1'b0, smpc_pkg::ADDR_IMR, 32'h0);
    chk("imr_clr", q[smpc_pkg::PC_DROP], 1'b0);
    // Reset control, then freeze
    uw(smpc_pkg::ADDR_SMON, smw(2'h1, s4, 1'b0, r4, 1'b0) | (32'h1 << smpc_pkg::SM_FRZ));
    sm_low <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("smon_por", {31'h0, smon_por_req}, 32'h1);
    sm_low <= 1'b0;
    uw(smpc_pkg::ADDR_SMON, smw(2'h0, 4'h0, 1'b0, 4'h0, 1'b0));
    smr("smon_frozen", smw(2'h1, s4, 1'b0, r4, 1'b1));
    chk("por_count", {24'h0, por_count}, 32'h1);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    // A later reset reloads the monitor and lifts the freeze
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    smr("smon_rst", smw(2'h0, smpc_pkg::SM_CAL_FACTORY, 1'b0, 4'h0, 1'b0));
    chk("smon_fcd2", {31'h0, q[smpc_pkg::SM_FCD]}, 32'h1);
    chk("reg_cal_keep", {24'h0, reg_cal}, {24'h0, c8});
    give_verdict();
  end
endmodule // tb_top
